//--- vpsc_pkg.sv
/*
  Constants and types for the ventricular pace suppression controller.
  Assumes a 100 MHz pclk and 32-bit APB register access.
*/
package vpsc_pkg;

  localparam int CLK_PERIOD_NS = 10;
  localparam int NS_PER_MS     = 1000000;
  localparam int CYC_PER_MS    = NS_PER_MS / CLK_PERIOD_NS;

  // Timing figures in their own units, then in milliseconds.
  localparam int AV_EXT_MS         = 450;
  localparam int SEARCH_BASE_S     = 30;
  localparam int SEARCH_LIMIT_MIN  = 128;
  localparam int SEARCH_SLOW_H     = 20;
  localparam int ADI_NO_VS_S       = 2;
  localparam int HOUR_MIN          = 60;
  localparam int SEARCH_BASE_MS    = SEARCH_BASE_S * 1000;
  localparam int SEARCH_SLOW_MS    = SEARCH_SLOW_H * 3600 * 1000;
  localparam int ADI_NO_VS_MS      = ADI_NO_VS_S * 1000;
  localparam int HOUR_MS           = HOUR_MIN * 60 * 1000;
  localparam int SEARCH_CYCLES     = 8;
  localparam int ADI_MISS_RUN      = 2;
  localparam int MAX_SWITCH_PER_H  = 15;
  // Index 0 is 30 s; doubling up to 128 min lands on index 8, index 9 is 20 h.
  localparam logic [3:0] IDX_LIMIT = 4'h8;
  localparam logic [3:0] IDX_SLOW  = 4'h9;

  // Register byte offsets.
  localparam logic [11:0] OFS_CTRL   = 12'h000;
  localparam logic [11:0] OFS_AVD    = 12'h004;
  localparam logic [11:0] OFS_STATUS = 12'h008;

  // CTRL fields.
  localparam int CTRL_MODE_LSB  = 0;
  localparam int CTRL_CONS_LSB  = 4;
  localparam int CTRL_XOF8_LSB  = 8;
  // STATUS fields.
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_LNCH_BIT  = 3;
  localparam int STAT_IDX_LSB   = 4;
  localparam int STAT_LOCK_BIT  = 8;
  localparam int STAT_SWC_LSB   = 9;

  // Programmed pacing mode encodings.
  localparam logic [1:0] MODE_TRACK     = 2'h0;
  localparam logic [1:0] MODE_SUPP      = 2'h1;
  localparam logic [1:0] MODE_SUPP_RATE = 2'h2;

  // Reset values.
  localparam logic [1:0] RST_MODE  = MODE_TRACK;
  localparam logic [2:0] RST_CONS  = 3'h3;
  localparam logic [2:0] RST_XOF8  = 3'h3;
  localparam logic [9:0] RST_AVD   = 10'h096;

  typedef enum logic [2:0] {
    ST_OFF    = 3'h0,
    ST_TRACK  = 3'h1,
    ST_SEARCH = 3'h3,
    ST_ADI    = 3'h2,
    ST_DDI    = 3'h6,
    ST_SUSP   = 3'h7
  } vpsc_state_t;

endpackage

//--- vpsc_ctrl.sv
/*
  Ventricular pace suppression controller: moves between tracking and
  atrial-pace dual-sense pacing, with continuity searches on a doubling schedule.
  Assumes event inputs are one-cycle pulses synchronous to pclk, and that the
  sense channel has already removed refractory and blanked events.
*/
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/10ps
module vpsc_ctrl #(
  parameter int CYC_PER_MS = vpsc_pkg::CYC_PER_MS
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        atrial_event,
  input  wire logic        ventricular_sense_event,
  input  wire logic        premature_ventricular_beat,
  input  wire logic        mode_switch_active,
  input  wire logic        priority_func_active,
  input  wire logic        midnight_pulse,
  output logic             ventricular_pace_event,
  output logic       [2:0] pacing_state,
  output logic       [9:0] av_delay_ms,
  output logic             search_active
);

  ////////////////////////////////////////////////////////////////////////////
  vpsc_pkg::vpsc_state_t state_ff, nxt_state;
  logic [31:0] prdata_ff;
  logic        pready_ff, pslverr_ff, pace_ff, srch_out_ff;
  logic [9:0]  avd_out_ff;
  logic [1:0]  mode_ff;
  logic [2:0]  cons_ff, xof8_ff;
  logic [9:0]  avd_ff;
  logic [16:0] tick_cnt_ff;
  logic        av_run_ff;
  logic [9:0]  av_ms_ff;
  logic        launch_ff;
  logic [26:0] intv_ms_ff;
  logic [3:0]  idx_ff;
  logic [3:0]  s_cyc_ff, s_run_ff;
  logic [10:0] nov_ms_ff;
  logic [1:0]  miss_run_ff;
  logic [7:0]  miss_win_ff;
  logic [3:0]  swc_ff;
  logic [21:0] hr_ms_ff;
  logic        lock_ff;

  function automatic logic [26:0] intv_of(input logic [3:0] idx);
    if (idx >= vpsc_pkg::IDX_SLOW) begin
      return 27'(vpsc_pkg::SEARCH_SLOW_MS);
    end
    return 27'(vpsc_pkg::SEARCH_BASE_MS) << idx;
  endfunction

  function automatic logic [3:0] ones8(input logic [7:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 8; i++) begin
      n = n + {3'h0, v[i]};
    end
    return n;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: zero wait states, pready is raised for the access phase.
  logic wr_en, sup_en;
  assign wr_en  = psel && penable && pwrite && pready_ff && clk_en;
  assign sup_en = (mode_ff == vpsc_pkg::MODE_SUPP) || (mode_ff == vpsc_pkg::MODE_SUPP_RATE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0;
    end else if (clk_en) begin
      pready_ff  <= psel && !penable;
      pslverr_ff <= psel && !penable && !(paddr == vpsc_pkg::OFS_CTRL || paddr == vpsc_pkg::OFS_AVD ||
                                          paddr == vpsc_pkg::OFS_STATUS);
      prdata_ff  <= 32'h0;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          vpsc_pkg::OFS_CTRL: begin
            prdata_ff <= 32'({xof8_ff, 1'b0, cons_ff, 2'h0, mode_ff});
          end
          vpsc_pkg::OFS_AVD: begin
            prdata_ff <= 32'(avd_ff);
          end
          vpsc_pkg::OFS_STATUS: begin
            prdata_ff <= 32'({swc_ff, lock_ff, idx_ff, launch_ff, state_ff});
          end
          default: begin
            prdata_ff <= 32'h0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_ff <= vpsc_pkg::RST_MODE;
      cons_ff <= vpsc_pkg::RST_CONS;
      xof8_ff <= vpsc_pkg::RST_XOF8;
      avd_ff  <= vpsc_pkg::RST_AVD;
    end else if (wr_en && paddr == vpsc_pkg::OFS_CTRL) begin
      mode_ff <= pwdata[vpsc_pkg::CTRL_MODE_LSB +: 2];
      cons_ff <= pwdata[vpsc_pkg::CTRL_CONS_LSB +: 3];
      xof8_ff <= pwdata[vpsc_pkg::CTRL_XOF8_LSB +: 3];
    end else if (wr_en && paddr == vpsc_pkg::OFS_AVD) begin
      avd_ff  <= pwdata[9:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Millisecond tick and AV delay timer.
  logic ms_tick, vs_any, in_search, in_adi;
  logic [9:0] av_limit;
  logic vs_win, av_out, cyc_end;
  assign ms_tick   = clk_en && (tick_cnt_ff == 17'(CYC_PER_MS - 1));
  assign vs_any    = ventricular_sense_event || premature_ventricular_beat;
  assign in_search = (state_ff == vpsc_pkg::ST_SEARCH);
  assign in_adi    = (state_ff == vpsc_pkg::ST_ADI);
  assign av_limit  = (in_search || in_adi) ? 10'(vpsc_pkg::AV_EXT_MS) : avd_ff;
  assign vs_win    = clk_en && av_run_ff && vs_any;
  assign av_out    = ms_tick && av_run_ff && !vs_any && (av_ms_ff + 10'h001 >= av_limit);
  assign cyc_end   = vs_win || av_out;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_ff <= 17'h0;
    end else if (clk_en) begin
      tick_cnt_ff <= ms_tick ? 17'h0 : tick_cnt_ff + 17'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      av_run_ff <= 1'b0;
      av_ms_ff  <= 10'h0;
    end else if (clk_en) begin
      if (atrial_event) begin
        av_run_ff <= 1'b1;
        av_ms_ff  <= 10'h0;
      end else if (cyc_end) begin
        av_run_ff <= 1'b0;
      end else if (ms_tick && av_run_ff) begin
        av_ms_ff  <= av_ms_ff + 10'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Search bookkeeping.
  logic s_hit, s_win, s_fail, intv_due, adi_exit;
  assign s_hit    = in_search && vs_win && ({1'b0, cons_ff} <= s_run_ff + 4'h1);
  assign s_win    = s_hit;
  assign s_fail   = in_search && cyc_end && !s_hit && (s_cyc_ff + 4'h1 >= 4'(vpsc_pkg::SEARCH_CYCLES));
  assign intv_due = (state_ff == vpsc_pkg::ST_TRACK) && ms_tick && (intv_ms_ff + 27'h1 >= intv_of(idx_ff));
  assign adi_exit = in_adi && clk_en && ((nov_ms_ff >= 11'(vpsc_pkg::ADI_NO_VS_MS)) ||
                    (av_out && miss_run_ff == 2'(vpsc_pkg::ADI_MISS_RUN - 1)) ||
                    (av_out && ones8({miss_win_ff[6:0], 1'b1}) >= {1'b0, xof8_ff}));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_cyc_ff <= 4'h0;
      s_run_ff <= 4'h0;
    end else if (clk_en) begin
      if (!in_search) begin
        s_cyc_ff <= 4'h0;
        s_run_ff <= 4'h0;
      end else if (cyc_end) begin
        s_cyc_ff <= s_cyc_ff + 4'h1;
        s_run_ff <= vs_win ? s_run_ff + 4'h1 : 4'h0;
      end
    end
  end

  // Interval index moves forward on failure, parks at the 20 h slot and returns to 0 on a successful search.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idx_ff <= 4'h0;
    end else if (clk_en) begin
      if (s_win) begin
        idx_ff <= 4'h0;
      end else if (s_fail && idx_ff < vpsc_pkg::IDX_SLOW) begin
        idx_ff <= idx_ff + 4'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      intv_ms_ff <= 27'h0;
    end else if (clk_en) begin
      if (state_ff != vpsc_pkg::ST_TRACK || intv_due || vs_win) begin
        intv_ms_ff <= 27'h0;
      end else if (ms_tick) begin
        intv_ms_ff <= intv_ms_ff + 27'h1;
      end
    end
  end

  // A new request is applied after the consumption so that it wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      launch_ff <= 1'b0;
    end else if (clk_en) begin
      if (nxt_state == vpsc_pkg::ST_SEARCH || !sup_en) begin
        launch_ff <= 1'b0;
      end
      if (sup_en && state_ff == vpsc_pkg::ST_OFF) begin
        launch_ff <= 1'b1;
      end
      if (state_ff == vpsc_pkg::ST_TRACK && (vs_win || intv_due)) begin
        launch_ff <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Dual-sense supervision and the switch-per-hour lock.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nov_ms_ff   <= 11'h0;
      miss_run_ff <= 2'h0;
      miss_win_ff <= 8'h0;
    end else if (clk_en) begin
      if (!in_adi || vs_any) begin
        nov_ms_ff <= 11'h0;
      end else if (ms_tick) begin
        nov_ms_ff <= nov_ms_ff + 11'h1;
      end
      if (!in_adi) begin
        miss_run_ff <= 2'h0;
        miss_win_ff <= 8'h0;
      end else if (cyc_end) begin
        miss_run_ff <= vs_win ? 2'h0 : miss_run_ff + 2'h1;
        miss_win_ff <= {miss_win_ff[6:0], av_out};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hr_ms_ff <= 22'h0;
      swc_ff   <= 4'h0;
      lock_ff  <= 1'b0;
    end else if (clk_en) begin
      if (ms_tick) begin
        hr_ms_ff <= (hr_ms_ff + 22'h1 >= 22'(vpsc_pkg::HOUR_MS)) ? 22'h0 : hr_ms_ff + 22'h1;
      end
      if (ms_tick && hr_ms_ff + 22'h1 >= 22'(vpsc_pkg::HOUR_MS)) begin
        swc_ff <= 4'h0;
      end else if (adi_exit) begin
        swc_ff <= swc_ff + 4'h1;
      end
      if (midnight_pulse) begin
        lock_ff <= 1'b0;
      end
      if (adi_exit && swc_ff + 4'h1 >= 4'(vpsc_pkg::MAX_SWITCH_PER_H)) begin
        lock_ff <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode sequencer. Nothing here clears the programmed mode, so suppression
  // is only ever paused, never given up.
  always_comb begin
    nxt_state = state_ff;
    if (!sup_en) begin
      nxt_state = vpsc_pkg::ST_OFF;
    end else if (mode_switch_active) begin
      nxt_state = vpsc_pkg::ST_DDI;
    end else if (priority_func_active) begin
      nxt_state = vpsc_pkg::ST_SUSP;
    end else begin
      unique case (state_ff)
        vpsc_pkg::ST_OFF, vpsc_pkg::ST_DDI, vpsc_pkg::ST_SUSP: begin
          nxt_state = vpsc_pkg::ST_TRACK;
        end
        vpsc_pkg::ST_TRACK: begin
          if (launch_ff && atrial_event && !lock_ff) begin
            nxt_state = vpsc_pkg::ST_SEARCH;
          end
        end
        vpsc_pkg::ST_SEARCH: begin
          if (s_win) begin
            nxt_state = vpsc_pkg::ST_ADI;
          end else if (s_fail) begin
            nxt_state = vpsc_pkg::ST_TRACK;
          end
        end
        vpsc_pkg::ST_ADI: begin
          if (adi_exit) begin
            nxt_state = vpsc_pkg::ST_TRACK;
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= vpsc_pkg::ST_OFF;
    end else if (clk_en) begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pace_ff     <= 1'b0;
      avd_out_ff  <= vpsc_pkg::RST_AVD;
      srch_out_ff <= 1'b0;
    end else if (clk_en) begin
      pace_ff     <= av_out && !in_adi;
      avd_out_ff  <= av_limit;
      srch_out_ff <= in_search;
    end
  end

  assign prdata                 = prdata_ff;
  assign pready                 = pready_ff;
  assign pslverr                = pslverr_ff;
  assign ventricular_pace_event = pace_ff;
  assign pacing_state           = state_ff;
  assign av_delay_ms            = avd_out_ff;
  assign search_active          = srch_out_ff;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_enable_edge;
    !sup_en ##1 (sup_en && clk_en && !mode_switch_active && !priority_func_active);
  endsequence

  a_enable_starts_track: assert property (s_enable_edge |=> state_ff == vpsc_pkg::ST_TRACK && launch_ff)
    else $error("enable did not start in tracking with a search pending");
  a_off_when_disabled: assert property (clk_en && !sup_en |=> state_ff == vpsc_pkg::ST_OFF)
    else $error("suppression active without a suppression mode");
  a_no_pace_adi: assert property (ventricular_pace_event |-> $past(state_ff) != vpsc_pkg::ST_ADI)
    else $error("ventricular pace in dual-sense mode");
  a_search_av_ext: assert property (clk_en && in_search |=> av_delay_ms == 10'(vpsc_pkg::AV_EXT_MS))
    else $error("search delay is not 450 ms");
  a_search_win_adi: assert property (s_win && clk_en && sup_en && !mode_switch_active && !priority_func_active
                                     |=> state_ff == vpsc_pkg::ST_ADI)
    else $error("successful search did not enter dual-sense mode");
  a_search_len_cap: assert property (in_search |-> s_cyc_ff < 4'(vpsc_pkg::SEARCH_CYCLES))
    else $error("search ran past 8 cycles");
  a_index_cap: assert property (idx_ff <= vpsc_pkg::IDX_SLOW)
    else $error("search interval index past the 20 h slot");
  a_ms_to_ddi: assert property (clk_en && sup_en && mode_switch_active |=> state_ff == vpsc_pkg::ST_DDI)
    else $error("mode switch did not force non-tracking mode");
  a_resume_track: assert property ((state_ff == vpsc_pkg::ST_DDI || state_ff == vpsc_pkg::ST_SUSP) && clk_en &&
                                   sup_en && !mode_switch_active && !priority_func_active
                                   |=> state_ff == vpsc_pkg::ST_TRACK)
    else $error("resume did not go through tracking");
  a_two_misses_exit: assert property (in_adi && av_out && miss_run_ff == 2'h1 && sup_en && !mode_switch_active &&
                                      !priority_func_active |=> state_ff == vpsc_pkg::ST_TRACK)
    else $error("two missed cycles did not return to tracking");

endmodule // vpsc_ctrl

//--- vpsc_heart.sv
/*
  Behavioural heart facing the pace suppression controller: atrial beats at a
  fixed period and an optional conducted ventricular sense or premature beat.
  Assumes the controller counts one ms per pclk cycle, as the bench sets it.
*/
`timescale 1ns/10ps
module vpsc_heart (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       conduct,
  input  wire logic       pvc_mode,
  input  wire logic [9:0] delay_ms,
  input  wire logic       ventricular_pace_event,
  output logic            atrial_event,
  output logic            ventricular_sense_event,
  output logic            premature_ventricular_beat
);
  localparam int PERIOD_MS = 600;
  int   cnt_ff;
  logic paced_ff;
  logic hit;

  ////////////////////////////////////////
  // A paced ventricle is refractory, so no sense follows a pace in the same beat.
  assign hit = conduct && !paced_ff && cnt_ff == int'(delay_ms);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 0;
      paced_ff <= 1'b0;
      atrial_event <= 1'b0;
      ventricular_sense_event <= 1'b0;
      premature_ventricular_beat <= 1'b0;
    end else begin
      cnt_ff <= (cnt_ff == PERIOD_MS - 1) ? 0 : cnt_ff + 1;
      atrial_event <= (cnt_ff == 0);
      if (cnt_ff == 0) begin
        paced_ff <= 1'b0;
      end else if (ventricular_pace_event) begin
        paced_ff <= 1'b1;
      end
      ventricular_sense_event <= hit && !pvc_mode;
      premature_ventricular_beat <= hit && pvc_mode;
    end
  end
endmodule // vpsc_heart

//--- vpsc_ctrl_tb.sv
/*
  Self-checking bench for the pace suppression controller with a heart model.
  Assumes the controller is built with one pclk cycle per ms to keep runs short.
*/
`timescale 1ns/10ps
module vpsc_ctrl_tb;
  logic        pclk;
  logic        presetn;
  logic        clk_en;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        atrial_event;
  logic        ventricular_sense_event;
  logic        premature_ventricular_beat;
  logic        mode_switch_active;
  logic        priority_func_active;
  logic        ventricular_pace_event;
  logic [2:0]  pacing_state;
  logic [9:0]  av_delay_ms;
  logic        search_active;
  logic        conduct;
  logic        pvc_mode;
  logic [9:0]  delay_ms;
  logic [31:0] rd;
  logic        er;
  logic [2:0]  cons;
  int          n_errors;
  int          checked;
  int          cyc;
  int          last_a;
  int          mdl_av;
  int          t0;
  bit          in_adi;

  vpsc_ctrl #(.CYC_PER_MS(1)) u_vpsc_ctrl (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .atrial_event(atrial_event), .ventricular_sense_event(ventricular_sense_event),
    .premature_ventricular_beat(premature_ventricular_beat), .mode_switch_active(mode_switch_active),
    .priority_func_active(priority_func_active), .midnight_pulse(1'b0),
    .ventricular_pace_event(ventricular_pace_event), .pacing_state(pacing_state),
    .av_delay_ms(av_delay_ms), .search_active(search_active));

  vpsc_heart u_vpsc_heart (
    .pclk(pclk), .presetn(presetn), .conduct(conduct), .pvc_mode(pvc_mode), .delay_ms(delay_ms),
    .ventricular_pace_event(ventricular_pace_event), .atrial_event(atrial_event),
    .ventricular_sense_event(ventricular_sense_event),
    .premature_ventricular_beat(premature_ventricular_beat));

  ////////////////////////////////////////
  always #5 pclk = ~pclk;

  task automatic report_and_stop;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr_ctrl(input logic [1:0] m);
    apb(1'b1, vpsc_pkg::OFS_CTRL, {21'h0, 3'h3, 1'b0, cons, 2'h0, m});
  endtask

  task automatic wait_state(input logic [2:0] s, input int lim);
    int k;
    k = 0;
    while (pacing_state !== s && k < lim) begin
      @(posedge pclk);
      k++;
    end
  endtask

  // The expected AV delay is armed only from the next atrial beat, so a beat
  // that straddles a mode change is never judged against the wrong delay.
  task automatic sync_av(input int v);
    int k;
    mdl_av = 0;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (atrial_event !== 1'b1 && k < 700);
    mdl_av = v;
  endtask

  ////////////////////////////////////////
  always @(posedge pclk) begin
    cyc++;
    if (atrial_event === 1'b1) begin
      last_a = cyc;
    end
    if (ventricular_pace_event === 1'b1 && in_adi) begin
      chk(1'b1, 1'b0, "pace in dual-sense");
    end else if (ventricular_pace_event === 1'b1 && mdl_av != 0) begin
      chk(cyc - last_a >= mdl_av - 1 && cyc - last_a <= mdl_av + 3, 1'b1, "pace delay");
    end
    if (cyc > 100000) begin
      n_errors++;
      report_and_stop();
    end
  end

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    clk_en = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {mode_switch_active, priority_func_active, conduct, pvc_mode} = '0;
    delay_ms = 10'h12c;
    {n_errors, checked, cyc, last_a, mdl_av} = '0;
    in_adi = 1'b0;
    void'($urandom(32'h1e81));
    cons = 3'($urandom_range(4, 1));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, vpsc_pkg::OFS_CTRL, 32'h0);
    chk(rd, 32'h00000330, "ctrl reset");
    apb(1'b0, vpsc_pkg::OFS_AVD, 32'h0);
    chk(rd, 32'h00000096, "avd reset");
    apb(1'b1, vpsc_pkg::OFS_STATUS, 32'hffffffff);
    chk(er, 1'b0, "status write");
    apb(1'b0, vpsc_pkg::OFS_STATUS, 32'h0);
    chk(rd, 32'h0, "status reset");
    apb(1'b0, 12'h00c, 32'h0);
    chk({rd, er}, 33'h1, "unmapped");
    for (int m = 3; m >= 0; m--) begin
      wr_ctrl(2'(m));
      repeat (3) @(posedge pclk);
      chk(pacing_state !== 3'h0, m == 1 || m == 2, "enable by mode");
    end
    sync_av(150);
    wr_ctrl(vpsc_pkg::MODE_SUPP);
    wait_state(vpsc_pkg::ST_SEARCH, 700);
    chk(pacing_state, vpsc_pkg::ST_SEARCH, "first search");
    t0 = cyc;
    sync_av(450);
    chk(av_delay_ms, 10'd450, "search delay");
    chk(search_active, 1'b1, "search flag");
    wait_state(vpsc_pkg::ST_TRACK, 6000);
    chk(pacing_state, vpsc_pkg::ST_TRACK, "failed search");
    chk(cyc - t0 >= 4200 && cyc - t0 <= 5400, 1'b1, "eight beats");
    sync_av(150);
    chk(av_delay_ms, 10'd150, "tracking delay");
    apb(1'b0, vpsc_pkg::OFS_STATUS, 32'h0);
    chk(rd[7:0], {4'h1, 1'b0, vpsc_pkg::ST_TRACK}, "doubled interval");
    delay_ms <= 10'($urandom_range(120, 60));
    pvc_mode <= 1'b1;
    conduct <= 1'b1;
    wait_state(vpsc_pkg::ST_SEARCH, 1400);
    chk(pacing_state, vpsc_pkg::ST_SEARCH, "premature beat search");
    pvc_mode <= 1'b0;
    mdl_av = 0;
    wait_state(vpsc_pkg::ST_ADI, 6000);
    chk(pacing_state, vpsc_pkg::ST_ADI, "search success");
    delay_ms <= 10'd300;
    in_adi = 1'b1;
    repeat (1800) @(posedge pclk);
    chk({pacing_state, av_delay_ms}, {vpsc_pkg::ST_ADI, 10'd450}, "dual-sense");
    conduct <= 1'b0;
    in_adi = 1'b0;
    t0 = cyc;
    wait_state(vpsc_pkg::ST_TRACK, 2000);
    chk(cyc - t0 <= 1400, 1'b1, "two missed beats");
    t0 = cyc;
    sync_av(150);
    wait_state(vpsc_pkg::ST_SEARCH, 32000);
    chk(cyc - t0 >= 30000 && cyc - t0 <= 31300, 1'b1, "timed search");
    mdl_av = 0;
    mode_switch_active <= 1'b1;
    conduct <= 1'b1;
    wait_state(vpsc_pkg::ST_DDI, 10);
    chk(pacing_state, vpsc_pkg::ST_DDI, "mode switch");
    repeat (1300) @(posedge pclk);
    mode_switch_active <= 1'b0;
    wait_state(vpsc_pkg::ST_TRACK, 10);
    repeat (1300) @(posedge pclk);
    chk(pacing_state, vpsc_pkg::ST_TRACK, "resync to tracking");
    priority_func_active <= 1'b1;
    wait_state(vpsc_pkg::ST_SUSP, 10);
    chk(pacing_state, vpsc_pkg::ST_SUSP, "interrupted");
    priority_func_active <= 1'b0;
    wait_state(vpsc_pkg::ST_TRACK, 10);
    chk(pacing_state, vpsc_pkg::ST_TRACK, "reactivated");
    // With the clock enable low the sequencer must ignore the interruption.
    clk_en <= 1'b0;
    priority_func_active <= 1'b1;
    repeat (20) @(posedge pclk);
    chk(pacing_state, vpsc_pkg::ST_TRACK, "frozen by clock enable");
    clk_en <= 1'b1;
    wait_state(vpsc_pkg::ST_SUSP, 10);
    chk(pacing_state, vpsc_pkg::ST_SUSP, "interrupt after enable");
    priority_func_active <= 1'b0;
    report_and_stop();
  end
endmodule // vpsc_ctrl_tb
